//--- hw/logic_cell_gate_input_select.sv
// gate 0..2 input selection, polarity and data source pick of a logic cell
//
// Functional notes
// - gate 0 byte: in4 pair at bits 7/6
// - gate 0 true bit admits plain input
// - gate 0 negated bit admits inverted input
// - gate 1 byte uses the same pairing
// - gate 1 true bit admits plain input
// - gate 1 negated bit admits inverted input
// - gate 2 byte uses the same pairing
// - gate 2 true bit admits plain input
// - gate 2 negated bit admits inverted input
// - all selection bits read/write, only reset-cleared
// - per-gate polarity bit inverts gate output
// - each data input picked by 6-bit source field
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "gate_sel_cfg.svh"

module logic_cell_gate_input_select (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // register port
  input  wire gate_sel_pkg::reg_req_s     req,
  output logic [`GS_DATA_W-1:0]           rd_data,
  // candidate sources for the four data inputs
  input  wire logic [`GS_SRC_N-1:0]       src_bus,
  // chosen data inputs and gate results
  output logic [3:0]                      cell_data,
  output logic [2:0]                      gate_out
);

  //////////////////////////////////////////////////////////////////////
  // functions

  // OR of every admitted true and inverted term
  function automatic logic gate_or(
    input gate_sel_pkg::gate_sel_s s,
    input logic [3:0]              d
  );
    gate_or = (s.in1_true_sel &  d[0]) |
              (s.in1_inv_sel  & ~d[0]) |
              (s.in2_true_sel &  d[1]) |
              (s.in2_inv_sel  & ~d[1]) |
              (s.in3_true_sel &  d[2]) |
              (s.in3_inv_sel  & ~d[2]) |
              (s.in4_true_sel &  d[3]) |
              (s.in4_inv_sel  & ~d[3]);
  endfunction

  // address match for a write
  function automatic logic wr_hit(
    input gate_sel_pkg::reg_req_s r,
    input logic [`GS_ADDR_W-1:0]  off
  );
    wr_hit = r.wr & (r.addr == off);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state

  // gate selection bytes
  gate_sel_pkg::gate_sel_s g0_sel_ff;
  gate_sel_pkg::gate_sel_s g1_sel_ff;
  gate_sel_pkg::gate_sel_s g2_sel_ff;
  // per-gate output inversion, bit n for gate n
  logic [`GS_POL_W-1:0]    gate_output_invert_ff;
  // source field of each data input
  logic [`GS_SRC_W-1:0]    src_sel_ff [4];
  // registered outputs
  logic [`GS_DATA_W-1:0]   rd_data_ff;
  logic [3:0]              cell_data_ff;
  logic [2:0]              gate_out_ff;

  //////////////////////////////////////////////////////////////////////
  // write decode

  // one strobe per writable register
  wire hit_g0  = wr_hit(req, `GS_OFF_G0);
  wire hit_g1  = wr_hit(req, `GS_OFF_G1);
  wire hit_g2  = wr_hit(req, `GS_OFF_G2);
  wire hit_pol = wr_hit(req, `GS_OFF_POL);
  // source register strobes
  wire [3:0] hit_src = {wr_hit(req, `GS_OFF_SRC3),
                        wr_hit(req, `GS_OFF_SRC2),
                        wr_hit(req, `GS_OFF_SRC1),
                        wr_hit(req, `GS_OFF_SRC0)};

  // write data seen as a selection byte
  wire gate_sel_pkg::gate_sel_s wsel = req.wdata;

  //////////////////////////////////////////////////////////////////////
  // gate selection registers

  // power-on value is unknown, so they clear on the only reset we have;
  // software must still program them before trusting a gate
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      g0_sel_ff <= `GS_SEL_RST;
      g1_sel_ff <= `GS_SEL_RST;
      g2_sel_ff <= `GS_SEL_RST;
    end else begin
      if (hit_g0) begin
        g0_sel_ff <= wsel;
      end
      if (hit_g1) begin
        g1_sel_ff <= wsel;
      end
      if (hit_g2) begin
        g2_sel_ff <= wsel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // polarity register

  // only bits 2..0 exist, the rest are dropped on write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_output_invert_ff <= `GS_POL_RST;
    end else if (hit_pol) begin
      gate_output_invert_ff <= req.wdata[`GS_POL_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // data source selection

  // chosen source of each data input
  logic [3:0] src_pick;

  for (genvar i = 0; i < 4; i++) begin : g_src
    // 6-bit field per input, upper bits of the byte ignored
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        src_sel_ff[i] <= `GS_SRC_RST;
      end else if (hit_src[i]) begin
        src_sel_ff[i] <= req.wdata[`GS_SRC_W-1:0];
      end
    end
    // plain index into the candidate bus
    assign src_pick[i] = src_bus[src_sel_ff[i]];
  end

  // sample the chosen sources once, so every gate sees the same values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cell_data_ff <= 4'h0;
    end else begin
      cell_data_ff <= src_pick;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gates

  // raw OR of each gate before polarity
  wire g0_raw = gate_or(g0_sel_ff, cell_data_ff);
  wire g1_raw = gate_or(g1_sel_ff, cell_data_ff);
  wire g2_raw = gate_or(g2_sel_ff, cell_data_ff);

  // polarity applied after the OR, not to the terms
  wire [2:0] gate_nxt = {g2_raw, g1_raw, g0_raw} ^
                        gate_output_invert_ff;

  // registered gate results, one cycle behind cell_data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_out_ff <= 3'h0;
    end else begin
      gate_out_ff <= gate_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read path

  // status byte: chosen inputs high, gate results low
  wire [`GS_DATA_W-1:0] stat_word = {cell_data_ff, 1'b0, gate_out_ff};

  // read mux; unmapped offsets and unused bits read as zero
  wire [`GS_DATA_W-1:0] rd_mux =
    (req.addr == `GS_OFF_G0)   ? g0_sel_ff :
    (req.addr == `GS_OFF_G1)   ? g1_sel_ff :
    (req.addr == `GS_OFF_G2)   ? g2_sel_ff :
    (req.addr == `GS_OFF_POL)  ? {5'h00, gate_output_invert_ff} :
    (req.addr == `GS_OFF_SRC0) ? {2'h0, src_sel_ff[0]} :
    (req.addr == `GS_OFF_SRC1) ? {2'h0, src_sel_ff[1]} :
    (req.addr == `GS_OFF_SRC2) ? {2'h0, src_sel_ff[2]} :
    (req.addr == `GS_OFF_SRC3) ? {2'h0, src_sel_ff[3]} :
    (req.addr == `GS_OFF_STAT) ? stat_word :
    `GS_RD_IDLE;

  // data stands only in the cycle after the read strobe
  wire [`GS_DATA_W-1:0] nxt_rd_data = req.rd ? rd_mux : `GS_RD_IDLE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_ff <= `GS_RD_IDLE;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign rd_data   = rd_data_ff;
  assign cell_data = cell_data_ff;
  assign gate_out  = gate_out_ff;

  //////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // write to gate 0 followed by a read of it
  sequence g0_wr_s;
    req.wr && req.addr == `GS_OFF_G0;
  endsequence
  sequence g0_rd_s;
    req.rd && req.addr == `GS_OFF_G0;
  endsequence

  wr_rd_back_a: assert property (
    g0_wr_s ##1 g0_rd_s |=> rd_data == $past(req.wdata, 2))
    else $error("gate 0 readback differs from written byte");

  rd_idle_a: assert property (
    !req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside read slot");

  g1_layout_a: assert property (
    req.rd && req.addr == `GS_OFF_G1 |=> rd_data == $past(g1_sel_ff))
    else $error("gate 1 byte not returned in place");

  g0_true_a: assert property (
    g0_sel_ff == 8'h80 && !gate_output_invert_ff[0]
    |=> gate_out[0] == $past(cell_data_ff[3]))
    else $error("gate 0 true term of input 4 wrong");

  g0_inv_a: assert property (
    g0_sel_ff == 8'h40 && !gate_output_invert_ff[0]
    |=> gate_out[0] == !$past(cell_data_ff[3]))
    else $error("gate 0 negated term of input 4 wrong");

  g1_true_a: assert property (
    g1_sel_ff == 8'h02 && !gate_output_invert_ff[1]
    |=> gate_out[1] == $past(cell_data_ff[0]))
    else $error("gate 1 true term of input 1 wrong");

  g1_inv_a: assert property (
    g1_sel_ff == 8'h01 && !gate_output_invert_ff[1]
    |=> gate_out[1] == !$past(cell_data_ff[0]))
    else $error("gate 1 negated term of input 1 wrong");

  g2_true_a: assert property (
    g2_sel_ff == 8'h20 && !gate_output_invert_ff[2]
    |=> gate_out[2] == $past(cell_data_ff[2]))
    else $error("gate 2 true term of input 3 wrong");

  g2_inv_a: assert property (
    g2_sel_ff == 8'h04 && !gate_output_invert_ff[2]
    |=> gate_out[2] == !$past(cell_data_ff[1]))
    else $error("gate 2 negated term of input 2 wrong");

  empty_gate_a: assert property (
    g0_sel_ff == 8'h00 |=> gate_out[0] == $past(gate_output_invert_ff[0]))
    else $error("empty gate 0 not at polarity level");

  pol_flip_a: assert property (
    g2_sel_ff == 8'h00 && gate_output_invert_ff[2] |=> gate_out[2])
    else $error("gate 2 polarity not applied");

  src_pick_a: assert property (
    1'b1 |=> cell_data[0] == $past(src_bus[src_sel_ff[0]]))
    else $error("data input 1 not from selected source");

  g0_layout_a: assert property (
    req.wr && req.addr == `GS_OFF_G0
    |=> g0_sel_ff.in4_true_sel == $past(req.wdata[7]) &&
        g0_sel_ff.in1_inv_sel == $past(req.wdata[0]))
    else $error("gate 0 byte layout wrong");

  g2_layout_a: assert property (
    req.wr && req.addr == `GS_OFF_G2
    |=> g2_sel_ff.in3_true_sel == $past(req.wdata[5]))
    else $error("gate 2 byte layout wrong");

  // offsets past the status byte decode to nothing and read as zero
  unmapped_rd_a: assert property (
    req.rd && req.addr > `GS_OFF_STAT |=> rd_data == 8'h00)
    else $error("unmapped offset read not zero");

  // polarity byte reads back with its unused upper bits at zero
  pol_rd_a: assert property (
    req.rd && req.addr == `GS_OFF_POL
    |=> rd_data == {5'h00, $past(gate_output_invert_ff)})
    else $error("polarity byte readback wrong");

endmodule

//--- include/gate_sel_cfg.svh
// offsets, field positions, reset values for the gate input selector
`ifndef GATE_SEL_CFG_SVH
`define GATE_SEL_CFG_SVH

// register bus geometry
`define GS_ADDR_W      4
`define GS_DATA_W      8

// register offsets (word index on the plain port)
`define GS_OFF_G0      4'h0
`define GS_OFF_G1      4'h1
`define GS_OFF_G2      4'h2
`define GS_OFF_POL     4'h3
`define GS_OFF_SRC0    4'h4
`define GS_OFF_SRC1    4'h5
`define GS_OFF_SRC2    4'h6
`define GS_OFF_SRC3    4'h7
`define GS_OFF_STAT    4'h8

// field widths and positions
`define GS_SRC_W       6
`define GS_SRC_N       64
`define GS_POL_W       3
`define GS_STAT_DIN_LSB 4

// reset values
`define GS_SEL_RST     8'h00
`define GS_POL_RST     3'h0
`define GS_SRC_RST     6'h00
`define GS_RD_IDLE     8'h00

`endif

//--- include/gate_sel_pkg.sv
// types shared by the gate input selector and its bench
package gate_sel_pkg;
`include "gate_sel_cfg.svh"

  // one register bus request, sampled on a rising edge
  typedef struct packed {
    logic [`GS_ADDR_W-1:0] addr;
    logic [`GS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_s;

  // one gate selection byte, msb first
  typedef struct packed {
    logic in4_true_sel;
    logic in4_inv_sel;
    logic in3_true_sel;
    logic in3_inv_sel;
    logic in2_true_sel;
    logic in2_inv_sel;
    logic in1_true_sel;
    logic in1_inv_sel;
  } gate_sel_s;

endpackage

//--- dv/tb_top.sv
// self-checking bench for the gate input selector block
`timescale 1ns/100ps
`include "gate_sel_cfg.svh"
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_top;
  //////////////////////////////////////////////////////////////////////////
  // design connections
  logic                    clk = 1'b0;  // 10 MHz bench clock
  logic                    arst_n;      // async reset, active low
  gate_sel_pkg::reg_req_s  req;         // register port request
  logic [`GS_DATA_W-1:0]   rd_data;     // read answer, one cycle late
  logic [`GS_SRC_N-1:0]    src_bus;     // candidate sources
  logic [3:0]              cell_data;   // chosen data inputs
  logic [2:0]              gate_out;    // gate results
  // bookkeeping
  int                      err_count;   // mismatches
  int                      comparisons; // compares made
  int                      seed;        // random seed
  logic [7:0]              rq[$];       // expected read data
  logic [3:0]              cq[$];       // expected data inputs
  logic [2:0]              gq[$];       // expected gate results
  logic [7:0]              sel_m[3];    // shadow of selection bytes
  logic [2:0]              pol_m;       // shadow of polarity bits
  logic [5:0]              src_m[4];    // shadow of source fields
  logic [3:0]              last_c;      // last expected data inputs
  logic [2:0]              last_g;      // last expected gate results
  logic                    drv_active;  // data driven this cycle
  logic                    rd_pend;     // read taken at next edge
  logic                    c_pend;      // data inputs due now
  logic                    g_pend;      // gate results due now
  logic [7:0]              re;          // popped read value
  logic [3:0]              ce;          // popped data inputs
  logic [2:0]              ge;          // popped gate results

  logic_cell_gate_input_select DUT (
    .clk       (clk),
    .arst_n    (arst_n),
    .req       (req),
    .rd_data   (rd_data),
    .src_bus   (src_bus),
    .cell_data (cell_data),
    .gate_out  (gate_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // clock, half period 50 ns; starts low with no edge at time zero
  initial begin
    forever #50 clk = ~clk;
  end

  // one bus cycle; signals held until the next call, the task never clears them
  task automatic bus(input logic [3:0] a, input logic [7:0] d,
                     input logic w, input logic r);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clk);
  endtask

  // read with its expected value noted first
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(a, 8'h00, 1'b0, 1'b1);
  endtask

  // gate model: or of admitted terms, then polarity
  function automatic logic [2:0] gate_calc(input logic [3:0] c);
    logic [7:0] t;
    logic [2:0] g;
    t = {c[3], ~c[3], c[2], ~c[2], c[1], ~c[1], c[0], ~c[0]};
    for (int n = 0; n < 3; n++) g[n] = pol_m[n] ^ (|(sel_m[n] & t));
    return g;
  endfunction

  // random sources each cycle; registers stay still meanwhile
  task automatic data_run(input int n);
    logic [63:0] v;
    logic [3:0]  c;
    for (int i = 0; i < n; i++) begin
      v = {$random(seed), $random(seed)};
      for (int k = 0; k < 4; k++) c[k] = v[src_m[k]];
      src_bus <= v;
      last_c = c;
      last_g = gate_calc(c);
      cq.push_back(c);
      gq.push_back(last_g);
      drv_active = 1'b1;
      @(posedge clk);
    end
    drv_active = 1'b0;
  endtask

  // verdict and end of run
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // monitor at the falling edge, where outputs have settled
  always @(negedge clk) begin
    if (g_pend) begin
      ge = gq.pop_front();
      `CHK("gate_out", ge, gate_out)
    end
    if (c_pend) begin
      ce = cq.pop_front();
      `CHK("cell_data", ce, cell_data)
    end
    if (rd_pend) begin
      re = rq.pop_front();
      `CHK("rd_data", re, rd_data)
    end else begin
      `CHK("rd_data idle", 8'h00, rd_data)
    end
    g_pend = c_pend;
    c_pend = drv_active;
    rd_pend = req.rd;
  end

  // watchdog; whole run needs about 920 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h696A;
    err_count = 0;
    comparisons = 0;
    arst_n = 1'b0;
    req = '0;
    src_bus = '0;
    drv_active = 1'b0;
    rd_pend = 1'b0;
    c_pend = 1'b0;
    g_pend = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values, unmapped offset included
    for (int a = 0; a < 9; a++) rd_chk(4'(a), 8'h00);
    rd_chk(4'hF, 8'h00);
    // all ones written, read back right after: width masks apply
    for (int a = 0; a < 9; a++) begin
      bus((a == 8) ? 4'hF : 4'(a), 8'hFF, 1'b1, 1'b0);
      rd_chk((a == 8) ? 4'hF : 4'(a), (a < 3) ? 8'hFF : (a == 3) ? 8'h07 :
             (a < 8) ? 8'h3F : 8'h00);
    end
    // walking single bits, then all three gates empty, then random setups
    for (int t = 0; t < 40; t++) begin
      for (int g = 0; g < 3; g++) begin
        sel_m[g] = (t < 24) ? ((t / 8 == g) ? 8'h01 << (t % 8) : 8'h00) :
                   (t == 24) ? 8'h00 : 8'($random(seed));
      end
      pol_m = (t < 24) ? 3'h0 : (t == 24) ? 3'h7 : 3'($random(seed));
      for (int k = 0; k < 4; k++) src_m[k] = 6'($random(seed));
      for (int g = 0; g < 3; g++) bus(4'(g), sel_m[g], 1'b1, 1'b0);
      bus(`GS_OFF_POL, {5'h00, pol_m}, 1'b1, 1'b0);
      for (int k = 0; k < 4; k++)
        bus(4'(`GS_OFF_SRC0 + k), {2'b00, src_m[k]}, 1'b1, 1'b0);
      rd_chk(4'(t % 3), sel_m[t % 3]);
      bus(4'h0, 8'h00, 1'b0, 1'b0);
      data_run(8);
      // sources hold still; status mirrors the last results
      repeat (2) bus(4'h0, 8'h00, 1'b0, 1'b0);
      rd_chk(`GS_OFF_STAT, {last_c, 1'b0, last_g});
      bus(4'h0, 8'h00, 1'b0, 1'b0);
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule
